// >>> logic/xfer_pkg.sv
// Package holding encodings, field positions and constants of the transfer sequencer
package xfer_pkg;
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int PRE_BIT = 24;
  localparam int UP_BIT = 23;
  localparam int USER_BIT = 22;
  localparam int WB_BIT = 21;
  localparam int LOAD_BIT = 20;
  localparam int BASE_HI = 19;
  localparam int BASE_LO = 16;
  localparam int NREGS = 16;
  localparam logic [3:0] PC_INDEX = 4'h0_f;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] PC_STORE_OFFSET = 32'h0000_000c;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {CYC_N, CYC_S, CYC_I, CYC_IDLE} cyc_kind_t;
endpackage

// >>> logic/reg_port_if.sv
// Interface carrying the remaining register list and its lowest set index between sequencer and list scanner
`timescale 1ns/100ps
interface reg_port_if;
  logic [15:0] list;
  logic [3:0] lowest;
  logic found;
  modport scan (input list, output lowest, output found);
  modport seq (output list, input lowest, input found);
endinterface

// >>> logic/list_scan.sv
// Priority encoder finding the lowest set bit of the remaining register list
`timescale 1ns/100ps
module list_scan (
  reg_port_if.scan port
);
  logic [3:0] idx;
  always_comb
  begin
    idx = 4'h0;
    for (int i = xfer_pkg::NREGS - 1; i >= 0; i--)
    begin
      if (port.list[i])
      begin
        idx = 4'(i);
      end
    end
  end
  assign port.lowest = idx;
  assign port.found = |port.list;
endmodule

// >>> logic/block_transfer_sequencer.sv
// Multi-register load/store sequencer with write-back, user bank and abort recovery
`timescale 1ns/100ps
// How it works
// [RULE1] Execute only when condition is satisfied
// [RULE2] List bit n selects register n
// [RULE3] Software never gives an empty list
// [RULE4] Stored program counter is instruction plus 12
// [RULE5] Bit 20 direction, bit 21 write-back
// [RULE6] Up/down and pre/post shape addresses
// [RULE7] Ascending order, lowest register lowest address
// [RULE8] No write-back keeps base unless loaded
// [RULE9] Low address bits pass through unchanged
// [RULE10] User flag only in privileged modes
// [RULE11] Load with PC and flag restores status
// [RULE12] Store with PC and flag uses user bank
// [RULE13] Flag without PC uses user bank
// [RULE14] No write-back with user bank transfer
// [RULE15] No banked access right after user load
// [RULE16] Program counter never the base
// [RULE17] Base written back end of cycle two; code writes it in ST_DONE, later stored base words use the new value
// [RULE18] Loaded base beats written-back base
// [RULE19] Store abort: finish, trap, only write-back
// [RULE20] Load abort cancels this and later updates
// [RULE21] Load abort restores base, trap at end
// [RULE22] Cycle counts per load or store kind
// [RULE23] Four-byte step, decrement start base minus 4n
module block_transfer_sequencer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [31:0] instr_in,
  input wire logic [31:0] instr_addr_in,
  input wire logic cond_pass_in,
  input wire logic [31:0] base_value_in,
  input wire logic [31:0] reg_rdata_in,
  input wire logic [31:0] mem_rdata_in,
  input wire logic abort_in,
  output logic busy_out,
  output logic done_out,
  output logic [31:0] mem_addr_out,
  output logic mem_req_out,
  output logic mem_write_out,
  output logic mem_seq_out,
  output logic [31:0] mem_wdata_out,
  output logic [3:0] reg_index_out,
  output logic reg_user_out,
  output logic reg_we_out,
  output logic [31:0] reg_wdata_out,
  output logic status_restore_out,
  output logic abort_trap_out
);
  typedef enum {ST_IDLE, ST_XFER, ST_DRAIN, ST_INTERNAL, ST_PCEXTRA, ST_DONE} seq_state_t;

  seq_state_t state_r, state_nxt;
  logic [15:0] remain_r;
  logic [31:0] addr_r;
  logic [31:0] wb_value_r;
  logic [3:0] base_idx_r;
  logic load_r, wb_r, user_r, pc_in_r, restore_r, aborted_r, first_r, base_listed_r;
  logic [31:0] instr_addr_r;
  // Issue stage: word picked last cycle, goes on the bus at the next edge
  logic iss_valid_r;
  logic iss_seq_r;
  logic [31:0] iss_addr_r;
  logic [3:0] iss_idx_r;
  // Register index of the word now on the bus
  logic [3:0] bus_idx_r;

  reg_port_if scan_port ();
  assign scan_port.list = remain_r;
  list_scan u_scan (
    .port(scan_port)
  );

  // Instruction field decode
  wire [15:0] list_w = instr_in[xfer_pkg::NREGS-1:0]; // RULE2
  wire load_w = instr_in[xfer_pkg::LOAD_BIT]; // RULE5
  wire wb_w = instr_in[xfer_pkg::WB_BIT]; // RULE5
  wire up_w = instr_in[xfer_pkg::UP_BIT];
  wire pre_w = instr_in[xfer_pkg::PRE_BIT];
  wire sbit_w = instr_in[xfer_pkg::USER_BIT];
  wire pc_listed_w = list_w[xfer_pkg::PC_INDEX];
  wire [4:0] count_w = 5'($countones(list_w));
  wire [31:0] span_w = {25'h000_0000, count_w, 2'b00};
  // RULE6 RULE23: lowest address used and final base value
  wire [31:0] low_addr_w = up_w ? (pre_w ? base_value_in + xfer_pkg::WORD_STEP : base_value_in)
    : (pre_w ? base_value_in - span_w : base_value_in - span_w + xfer_pkg::WORD_STEP);
  wire [31:0] final_base_w = up_w ? base_value_in + span_w : base_value_in - span_w;
  wire accept_w = start_in && (state_r == ST_IDLE) && cond_pass_in; // RULE1
  wire base_listed_w = list_w[instr_in[xfer_pkg::BASE_HI:xfer_pkg::BASE_LO]];
  wire last_w = (remain_r & (remain_r - 16'h0001)) == 16'h0000;
  wire iss_pc_w = iss_idx_r == xfer_pkg::PC_INDEX;
  wire bus_load_w = mem_req_out && !mem_write_out;
  // The memory manager answers the registered bus within the same core cycle
  wire abort_now_w = (mem_req_out && abort_in) || aborted_r;
  // RULE20: loads stop updating registers once aborted
  wire load_ok_w = bus_load_w && !abort_now_w;
  // RULE17: a base stored after the first word carries the updated value
  wire iss_new_base_w = iss_idx_r == base_idx_r && wb_r && iss_seq_r;
  // RULE4: stored program counter value
  wire [31:0] store_data_w = iss_pc_w ? instr_addr_r + xfer_pkg::PC_STORE_OFFSET
    : (iss_new_base_w ? wb_value_r : reg_rdata_in);
  // RULE18 RULE19 RULE21: base written back or restored at completion
  wire base_final_we_w = load_r ? (aborted_r || (wb_r && !base_listed_r)) : wb_r;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (accept_w)
        begin
          state_nxt = ST_XFER;
        end
      ST_XFER:
        if (last_w)
        begin
          state_nxt = ST_DRAIN;
        end
      // RULE22: loads add an internal cycle, a program counter load one more
      ST_DRAIN:
        state_nxt = load_r ? ST_INTERNAL : ST_DONE;
      ST_INTERNAL:
        state_nxt = pc_in_r ? ST_PCEXTRA : ST_DONE;
      ST_PCEXTRA:
        state_nxt = ST_DONE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      remain_r <= 16'h0000;
      addr_r <= xfer_pkg::ZERO_WORD;
      wb_value_r <= xfer_pkg::ZERO_WORD;
      base_idx_r <= 4'h0;
      load_r <= 1'b0;
      wb_r <= 1'b0;
      user_r <= 1'b0;
      pc_in_r <= 1'b0;
      restore_r <= 1'b0;
      aborted_r <= 1'b0;
      first_r <= 1'b0;
      base_listed_r <= 1'b0;
      instr_addr_r <= xfer_pkg::ZERO_WORD;
      iss_valid_r <= 1'b0;
      iss_seq_r <= 1'b0;
      iss_addr_r <= xfer_pkg::ZERO_WORD;
      iss_idx_r <= 4'h0;
      bus_idx_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      iss_valid_r <= state_r == ST_XFER;
      iss_seq_r <= !first_r;
      iss_addr_r <= addr_r;
      iss_idx_r <= scan_port.lowest;
      bus_idx_r <= iss_idx_r;
      if (accept_w)
      begin
        remain_r <= list_w;
        addr_r <= low_addr_w; // RULE9
        wb_value_r <= wb_w ? final_base_w : base_value_in; // RULE8
        base_idx_r <= instr_in[xfer_pkg::BASE_HI:xfer_pkg::BASE_LO];
        load_r <= load_w;
        wb_r <= wb_w;
        user_r <= sbit_w && !(load_w && pc_listed_w); // RULE12 RULE13
        pc_in_r <= pc_listed_w;
        restore_r <= sbit_w && load_w && pc_listed_w;
        aborted_r <= 1'b0;
        first_r <= 1'b1;
        instr_addr_r <= instr_addr_in;
        base_listed_r <= base_listed_w;
      end
      else if (state_r != ST_IDLE)
      begin
        if (mem_req_out && abort_in)
        begin
          aborted_r <= 1'b1;
        end
        if (state_r == ST_XFER)
        begin
          remain_r <= remain_r & ~(16'h0001 << scan_port.lowest); // RULE7
          addr_r <= addr_r + xfer_pkg::WORD_STEP; // RULE23
          first_r <= 1'b0;
        end
      end
    end
  end

  // Output registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      mem_addr_out <= xfer_pkg::ZERO_WORD;
      mem_req_out <= 1'b0;
      mem_write_out <= 1'b0;
      mem_seq_out <= 1'b0;
      mem_wdata_out <= xfer_pkg::ZERO_WORD;
      reg_index_out <= 4'h0;
      reg_user_out <= 1'b0;
      reg_we_out <= 1'b0;
      reg_wdata_out <= xfer_pkg::ZERO_WORD;
      status_restore_out <= 1'b0;
      abort_trap_out <= 1'b0;
    end
    else
    begin
      busy_out <= state_nxt != ST_IDLE && state_nxt != ST_DONE;
      done_out <= state_r == ST_DONE;
      mem_req_out <= iss_valid_r;
      mem_write_out <= iss_valid_r && !load_r;
      mem_seq_out <= iss_valid_r && iss_seq_r; // RULE22
      mem_addr_out <= iss_addr_r; // RULE9
      mem_wdata_out <= store_data_w;
      reg_user_out <= user_r; // RULE12 RULE13
      reg_we_out <= 1'b0;
      reg_wdata_out <= mem_rdata_in;
      status_restore_out <= 1'b0;
      abort_trap_out <= 1'b0;
      if (load_ok_w)
      begin
        // Loaded word lands one cycle after its bus cycle
        reg_we_out <= 1'b1; // RULE18 RULE20
        reg_index_out <= bus_idx_r;
        // RULE11: status copied as program counter loads
        status_restore_out <= restore_r && bus_idx_r == xfer_pkg::PC_INDEX;
      end
      else if (state_r == ST_DONE)
      begin
        reg_we_out <= base_final_we_w; // RULE8 RULE17 RULE19 RULE21
        reg_index_out <= base_idx_r;
        reg_wdata_out <= wb_value_r;
        abort_trap_out <= abort_now_w; // RULE19 RULE21
      end
      else if (state_r == ST_XFER && !load_r)
      begin
        // Store read port points at the word being issued
        reg_index_out <= scan_port.lowest;
      end
    end
  end

  a_pc_store_value: assert property (@(posedge clk_in) disable iff (rst_in) // RULE4
    iss_valid_r && !load_r && iss_pc_w |=>
      mem_wdata_out == $past(instr_addr_r) + xfer_pkg::PC_STORE_OFFSET)
    else $error("stored program counter value wrong");
  a_no_update_abort: assert property (@(posedge clk_in) disable iff (rst_in) // RULE20
    bus_load_w && abort_now_w |=> !reg_we_out)
    else $error("register updated after abort");
  a_addr_step: assert property (@(posedge clk_in) disable iff (rst_in) // RULE23
    state_r == ST_XFER && $past(state_r) == ST_XFER |-> addr_r == $past(addr_r) + 32'h0000_0004)
    else $error("address step not four");
  a_cond_gate: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    state_r == ST_IDLE && start_in && !cond_pass_in |=> state_r == ST_IDLE)
    else $error("transfer ran with failed condition");
  a_trap_at_end: assert property (@(posedge clk_in) disable iff (rst_in) // RULE21
    abort_trap_out |-> done_out)
    else $error("abort trap before completion");
  a_restore_pc: assert property (@(posedge clk_in) disable iff (rst_in) // RULE11
    status_restore_out |-> reg_we_out && reg_index_out == xfer_pkg::PC_INDEX)
    else $error("status restored without program counter load");
  a_order_up: assert property (@(posedge clk_in) disable iff (rst_in) // RULE7
    state_r == ST_XFER && $past(state_r) == ST_XFER |-> scan_port.lowest > $past(scan_port.lowest))
    else $error("registers not ascending");
  a_store_no_trap_early: assert property (@(posedge clk_in) disable iff (rst_in) // RULE19
    state_r == ST_XFER && !last_w |=> !abort_trap_out)
    else $error("trap taken mid instruction");
endmodule

// >>> test/mem_partner.sv
// Memory and memory-manager model answering the sequencer's bus
`timescale 1ns/100ps
module mem_partner (
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] fault_addr_in,
  input wire logic fault_en_in,
  output logic [31:0] rdata_out,
  output logic abort_out
);
  // Read data is a pattern of the address; an idle bus shows its inverse
  assign rdata_out = req_in ? {addr_in[15:0], ~addr_in[15:0]} : {~addr_in[15:0], addr_in[15:0]};
  assign abort_out = fault_en_in && req_in && (addr_in == fault_addr_in);
endmodule

// >>> test/block_transfer_sequencer_tb_top.sv
// Self-checking bench for the block transfer sequencer
`timescale 1ns/100ps
module block_transfer_sequencer_tb_top;
  logic clk_in = 0, rst_in = 1, start_in = 0, cond_pass_in = 0, fault_en = 0, exp_restore = 0;
  logic [31:0] instr_in = '0, instr_addr_in = '0, base_value_in = '0, fault_addr = '0;
  logic [31:0] mem_rdata_in, mem_addr_out, mem_wdata_out, reg_wdata_out, reg_rdata_in, ins;
  logic abort_in, busy_out, done_out, mem_req_out, mem_write_out, mem_seq_out;
  logic reg_user_out, reg_we_out, status_restore_out, abort_trap_out;
  logic [3:0] reg_index_out, idx_d;
  logic [31:0] regs [16];
  logic [68:0] exp_q [$];
  int err_count = 0, tests_run = 0, traps = 0, cycles = 0, t;

  block_transfer_sequencer DUT (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
    .instr_in(instr_in), .instr_addr_in(instr_addr_in), .cond_pass_in(cond_pass_in),
    .base_value_in(base_value_in), .reg_rdata_in(reg_rdata_in), .mem_rdata_in(mem_rdata_in),
    .abort_in(abort_in), .busy_out(busy_out), .done_out(done_out), .mem_addr_out(mem_addr_out),
    .mem_req_out(mem_req_out), .mem_write_out(mem_write_out), .mem_seq_out(mem_seq_out),
    .mem_wdata_out(mem_wdata_out), .reg_index_out(reg_index_out), .reg_user_out(reg_user_out),
    .reg_we_out(reg_we_out), .reg_wdata_out(reg_wdata_out),
    .status_restore_out(status_restore_out), .abort_trap_out(abort_trap_out));

  mem_partner memory (.req_in(mem_req_out), .addr_in(mem_addr_out), .fault_addr_in(fault_addr),
    .fault_en_in(fault_en), .rdata_out(mem_rdata_in), .abort_out(abort_in));

  assign reg_rdata_in = regs[reg_index_out];

  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [68:0] exp, input logic [68:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watches the bus and register writes, keeps the register file model
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      complete_run();
    end
    if (mem_req_out)
      chk("xfer", exp_q.size() ? exp_q.pop_front() : 69'h1,
        {mem_write_out, mem_write_out ? idx_d : 4'h0, mem_addr_out,
        mem_write_out ? mem_wdata_out : 32'h0});
    idx_d <= reg_index_out;
    if (reg_we_out)
    begin
      regs[reg_index_out] <= reg_wdata_out;
      if (reg_index_out == 4'hf)
        chk("status", {68'h0, exp_restore}, {68'h0, status_restore_out});
      if (fault_en && reg_index_out == 4'hf)
        chk("pc kept", 69'h0, 69'h1);
    end
    if (abort_trap_out)
      traps++;
  end

  task automatic run_op(input logic [31:0] i, input logic [31:0] base, input logic cond);
    logic [31:0] a, fin, ia;
    logic [31:0] lv [16];
    int n, k, bf;
    logic first;
    n = $countones(i[15:0]);
    bf = i[19:16];
    ia = $urandom & 32'hffff_fffc;
    fin = i[23] ? base + 4 * n : base - 4 * n;
    a = i[23] ? base + (i[24] ? 4 : 0) : base - 4 * n + (i[24] ? 0 : 4);
    first = 1;
    traps = 0;
    exp_restore = i[22] && i[20];
    regs[bf] = base;
    for (k = 0; k < 16; k++)
      if (i[k] && cond)
      begin
        lv[k] = {a[15:0], ~a[15:0]};
        exp_q.push_back({!i[20], i[20] ? 4'h0 : k[3:0], a, i[20] ? 32'h0 : k == 15 ? ia + 32'h0000_000c
          : (k == bf && !first && i[21]) ? fin : regs[k]});
        a = a + 32'h0000_0004;
        first = 0;
      end
    @(posedge clk_in);
    #2;
    start_in = 1;
    instr_in = i;
    base_value_in = base;
    cond_pass_in = cond;
    instr_addr_in = ia;
    @(posedge clk_in);
    #2;
    start_in = 0;
    for (k = 0; k < (cond ? 80 : 12); k++)
    begin
      @(posedge clk_in);
      #1;
      if (done_out)
        break;
    end
    chk("done", {68'h0, cond}, {68'h0, done_out});
    chk("left", 69'h0, 69'(exp_q.size()));
    exp_q.delete();
    repeat (3) @(posedge clk_in);
    #1;
    chk("trap", 69'(fault_en), 69'(traps));
    if (!i[20] || !i[bf] || fault_en || !cond)
      chk("base", {37'h0, (cond && i[21]) ? fin : base}, {37'h0, regs[bf]});
    else
      chk("base", {37'h0, lv[bf]}, {37'h0, regs[bf]});
    if (cond && i[20] && !fault_en)
      for (k = 0; k < 16; k++)
        if (i[k] && k != bf)
          chk("loaded", {37'h0, lv[k]}, {37'h0, regs[k]});
  endtask

  initial
  begin
    void'($urandom(32'h4f7ab177));
    for (t = 0; t < 16; t++)
      regs[t] = $urandom;
    repeat (16) @(posedge clk_in);
    #2;
    rst_in = 0;
    // Every load/store and index mode, base second in the list
    for (t = 0; t < 8; t++)
      run_op({4'he, 3'b100, t[2], t[1], 1'b0, 1'b1, t[0], 4'h5, 16'h80a2}, 32'h0000_1000, 1);
    run_op({4'he, 3'b100, 5'b01101, 4'h3, 16'h8011}, 32'h0000_2002, 1);
    run_op({4'he, 3'b100, 5'b00010, 4'h0, 16'hffff}, 32'h0000_3000, 1);
    fault_en = 1;
    fault_addr = 32'h0000_1004;
    run_op({4'he, 3'b100, 5'b01011, 4'h5, 16'h80a2}, 32'h0000_1000, 1);
    run_op({4'he, 3'b100, 5'b01010, 4'h5, 16'h80a2}, 32'h0000_1000, 1);
    fault_en = 0;
    for (t = 0; t < 60; t++)
    begin
      ins = $urandom;
      ins[27:25] = 3'b100;
      if (ins[15:0] == 16'h0000)
        ins[0] = 1;
      if (ins[19:16] == 4'hf)
        ins[19:16] = 4'hd;
      ins[22] = ins[22] && ins[20] && ins[15];
      ins[21] = ins[21] && !ins[22];
      run_op(ins, $urandom, ($urandom % 8) != 0);
    end
    complete_run();
  end
endmodule
